// *** rtl/sfn_pkg.sv ***
// Purpose: constants and types for the status flag block
// Assumes: 40 MHz pclk, APB register access
// Notes:   bit positions are those of the first status word
// How it works
// - negative flag follows result sign; cleared at reset.
// - 32-bit accumulator results use bit 31 as sign.
// - 16-bit results use bit 15 as sign.
// - result check op sets negative from accumulator sign.
// - add and subtract take negative from truncated result top bit.
// - compares take negative from the exact, unclipped difference.
// - exact sign applies to all compare, minimum and maximum ops.
// - zero flag at bit 4 set on zero result; reset clears.
// - result check op sets zero flag when accumulator is zero.
// - carry flag at bit 3 follows carry out of additions.
// - add with operand shifted by 16 may only set carry.
// - subtract and compare: borrow clears carry, else set.
// - subtract with operand shifted by 16 may only clear carry.
// - carry cleared by reset, force ops set or clear it.
// - add with carry sums both operands and carry, updates carry.
// - 32-bit left shift loads carry with bit 32-count; zero clears.
// - 16-bit left shift loads carry with bit 16-count; zero clears.
// - 16-bit right shift loads carry with bit count-1; zero clears.
// - conditional ops read carry without changing it.
// - overflow flag sticks until reset, a test of it or a status word write.
package sfn_pkg;

    // ----------------------------------------------------------
    // register map
    // ----------------------------------------------------------
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam int         CTRL_EN_BIT = 0;
    localparam logic       CTRL_EN_RST = 1'b1;

    // ----------------------------------------------------------
    // status word bit positions and reset values
    // ----------------------------------------------------------
    localparam int   C_BIT    = 3;
    localparam int   Z_BIT    = 4;
    localparam int   N_BIT    = 5;
    localparam int   V_BIT    = 6;
    localparam logic FLAG_RST = 1'b0;

    // ----------------------------------------------------------
    // widths
    // ----------------------------------------------------------
    localparam int DW   = 32;
    localparam int HW   = 16;
    localparam int CNTW = 5;

    // ----------------------------------------------------------
    // flag-affecting operations
    // ----------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP    = 4'h0,
        OP_RESULT = 4'h1,
        OP_CHECK  = 4'h2,
        OP_ADD    = 4'h3,
        OP_ADDC   = 4'h4,
        OP_SUB    = 4'h5,
        OP_CMP    = 4'h6,
        OP_MIN    = 4'h7,
        OP_MAX    = 4'h8,
        OP_SHL    = 4'h9,
        OP_SHR    = 4'hA,
        OP_SETC   = 4'hB,
        OP_CLRC   = 4'hC,
        OP_COND   = 4'hD
    } sfn_op_t;

    // ----------------------------------------------------------
    // condition codes
    // ----------------------------------------------------------
    typedef enum logic [3:0] {
        CC_NEQ = 4'h0,
        CC_EQ  = 4'h1,
        CC_GT  = 4'h2,
        CC_GEQ = 4'h3,
        CC_LT  = 4'h4,
        CC_LEQ = 4'h5,
        CC_HI  = 4'h6,
        CC_HIS = 4'h7,
        CC_LO  = 4'h8,
        CC_LOS = 4'h9,
        CC_NOV = 4'hA,
        CC_OV  = 4'hB,
        CC_UNC = 4'hF
    } sfn_cc_t;

    // one request from the decoder
    typedef struct packed {
        logic            valid;
        sfn_op_t         op;
        logic            wide;
        logic            shift16;
        logic [CNTW-1:0] count;
        sfn_cc_t         cond;
        logic [DW-1:0]   a;
        logic [DW-1:0]   b;
    } sfn_req_t;

endpackage

// *** rtl/sfn_flags.sv ***
// Purpose: negative, zero, carry and overflow flag update logic
// Assumes: one request per cycle from the decoder, same clock
// Notes:   flags and results settle at the edge taking the request
`timescale 1ns/1ps
module sfn_flags (
    input  wire logic              pclk,         // cpu clock
    input  wire logic              presetn,      // async reset, low
    input  wire logic              psel,         // apb select
    input  wire logic              penable,      // apb access phase
    input  wire logic              pwrite,       // apb direction
    input  wire logic [7:0]        paddr,        // apb byte address
    input  wire logic [31:0]       pwdata,       // apb write data
    output logic                   pready,       // apb ready
    output logic [31:0]            prdata,       // apb read data
    output logic                   pslverr,      // apb error
    input  wire sfn_pkg::sfn_req_t req,          // decoder request
    output logic                   neg_flag,     // negative flag
    output logic                   zero_flag,    // zero flag
    output logic                   carry_flag,   // carry flag
    output logic                   ovf_flag,     // overflow flag
    output logic [31:0]            result,       // op result
    output logic                   result_valid, // result strobe
    output logic                   cond_true     // condition outcome
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    logic        n_q;
    logic        z_q;
    logic        c_q;
    logic        v_q;
    logic        n_d;
    logic        z_d;
    logic        c_d;
    logic        v_d;
    logic        en_q;
    logic [31:0] res_q;
    logic [31:0] res_d;
    logic        rv_q;
    logic        ct_q;
    logic        ct_d;
    logic        rdy_q;
    logic [31:0] rd_q;
    logic        err_q;

    // ----------------------------------------------------------
    // operand alignment
    // ----------------------------------------------------------
    logic [31:0] ax;
    logic [31:0] bx;
    logic [31:0] cin;
    logic [32:0] sum;
    logic [32:0] dif;
    logic [31:0] src;
    logic [32:0] shl;
    logic [32:0] shr;
    logic        take;
    logic        cmp_neg;
    logic        add_ovf;
    logic        sub_ovf;
    logic        v_tested;

    // narrow operands move to the top half so one adder serves both
    assign ax = req.wide ? req.a : {req.a[15:0], 16'h0000};
    assign bx = req.wide ? req.b : {req.b[15:0], 16'h0000};

    // carry-in lands at bit 0 or bit 16 to match alignment
    assign cin = (req.op != sfn_pkg::OP_ADDC) ? 32'h0000_0000 :
                 req.wide ? {31'h0000_0000, c_q} :
                 {15'h0000, c_q, 16'h0000};

    // sum includes carry for add-with-carry
    assign sum = {1'b0, ax} + {1'b0, bx} + {1'b0, cin};

    // difference; bit 32 marks a borrow
    assign dif = {1'b0, ax} - {1'b0, bx};

    // unaligned source for right shift
    assign src = req.wide ? req.a : {16'h0000, req.a[15:0]};

    // left shift keeps the last bit out at bit 32
    assign shl = {1'b0, ax} << req.count;

    // right shift keeps the last bit out at bit 0
    assign shr = {src, 1'b0} >> req.count;

    // exact sign of a-b: unlike signs decide on the minuend
    assign cmp_neg = (ax[31] ^ bx[31]) ? ax[31] : dif[31];

    // signed overflow of the clipped sum and difference
    assign add_ovf = (ax[31] == bx[31]) && (sum[31] != ax[31]);
    assign sub_ovf = (ax[31] != bx[31]) && (dif[31] != ax[31]);

    // request accepted only while updates are enabled
    assign take = req.valid && en_q;

    // conditions that look at overflow
    assign v_tested = (req.cond == sfn_pkg::CC_NOV) ||
                      (req.cond == sfn_pkg::CC_OV);

    // ----------------------------------------------------------
    // next flag values
    // ----------------------------------------------------------
    // default keeps every flag; each op touches only its own
    always_comb begin
        n_d   = n_q;
        z_d   = z_q;
        c_d   = c_q;
        v_d   = v_q;
        res_d = res_q;
        if (take) begin
            case (req.op)
                sfn_pkg::OP_RESULT: begin
                    n_d   = ax[31];
                    z_d   = (ax == 32'h0000_0000);
                    res_d = req.a;
                end
                sfn_pkg::OP_CHECK: begin
                    n_d   = req.a[31];
                    z_d   = (req.a == 32'h0000_0000);
                    res_d = req.a;
                end
                sfn_pkg::OP_ADD,
                sfn_pkg::OP_ADDC: begin
                    n_d = sum[31];
                    z_d = (sum[31:0] == 32'h0000_0000);
                    if (req.shift16 && (req.op == sfn_pkg::OP_ADD)) begin
                        c_d = c_q | sum[32];
                    end else begin
                        c_d = sum[32];
                    end
                    v_d   = v_q | add_ovf;
                    res_d = req.wide ? sum[31:0] :
                            {16'h0000, sum[31:16]};
                end
                sfn_pkg::OP_SUB: begin
                    n_d = dif[31];
                    z_d = (dif[31:0] == 32'h0000_0000);
                    if (req.shift16) begin
                        c_d = c_q & ~dif[32];
                    end else begin
                        c_d = ~dif[32];
                    end
                    v_d   = v_q | sub_ovf;
                    res_d = req.wide ? dif[31:0] :
                            {16'h0000, dif[31:16]};
                end
                sfn_pkg::OP_CMP: begin
                    n_d = cmp_neg;
                    z_d = (dif[31:0] == 32'h0000_0000);
                    c_d = ~dif[32];
                end
                sfn_pkg::OP_MIN: begin
                    n_d = cmp_neg;
                    z_d = (dif[31:0] == 32'h0000_0000);
                    c_d = ~dif[32];
                    v_d = v_q | cmp_neg;
                    res_d = cmp_neg ? req.a : req.b;
                end
                sfn_pkg::OP_MAX: begin
                    n_d = cmp_neg;
                    z_d = (dif[31:0] == 32'h0000_0000);
                    c_d = ~dif[32];
                    v_d = v_q | (~cmp_neg & (dif[31:0] != 32'h0000_0000));
                    res_d = cmp_neg ? req.b : req.a;
                end
                sfn_pkg::OP_SHL: begin
                    c_d = shl[32];
                    n_d = shl[31];
                    z_d = (shl[31:0] == 32'h0000_0000);
                    res_d = req.wide ? shl[31:0] :
                            {16'h0000, shl[31:16]};
                end
                sfn_pkg::OP_SHR: begin
                    c_d = shr[0];
                    n_d = req.wide ? shr[32] : shr[16];
                    z_d = (shr[32:1] == 32'h0000_0000);
                    res_d = shr[32:1];
                end
                sfn_pkg::OP_SETC: begin
                    c_d = 1'b1;
                end
                sfn_pkg::OP_CLRC: begin
                    c_d = 1'b0;
                end
                sfn_pkg::OP_COND: begin
                    // carry only read here, never written
                    c_d = c_q;
                    if (v_tested) begin
                        v_d = 1'b0;
                    end
                end
                default: begin
                    n_d = n_q;
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // condition test on the flags as they stand
    // ----------------------------------------------------------
    // flags from the previous op are already in the flops
    always_comb begin
        case (req.cond)
            sfn_pkg::CC_NEQ: ct_d = ~z_q;
            sfn_pkg::CC_EQ:  ct_d = z_q;
            sfn_pkg::CC_GT:  ct_d = ~z_q & ~n_q;
            sfn_pkg::CC_GEQ: ct_d = ~n_q;
            sfn_pkg::CC_LT:  ct_d = n_q;
            sfn_pkg::CC_LEQ: ct_d = z_q | n_q;
            sfn_pkg::CC_HI:  ct_d = c_q & ~z_q;
            sfn_pkg::CC_HIS: ct_d = c_q;
            sfn_pkg::CC_LO:  ct_d = ~c_q;
            sfn_pkg::CC_LOS: ct_d = ~c_q | z_q;
            sfn_pkg::CC_NOV: ct_d = ~v_q;
            sfn_pkg::CC_OV:  ct_d = v_q;
            sfn_pkg::CC_UNC: ct_d = 1'b1;
            default:         ct_d = 1'b0;
        endcase
    end

    // ----------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------
    logic acc;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_ctrl;
    logic wr_stat;

    // access phase, answered one cycle later
    assign acc      = psel && penable && !rdy_q;
    assign hit_ctrl = (paddr == sfn_pkg::CTRL_OFS);
    assign hit_stat = (paddr == sfn_pkg::STATUS_OFS);
    assign wr_ctrl  = acc && pwrite && hit_ctrl;
    assign wr_stat  = acc && pwrite && hit_stat;

    // ----------------------------------------------------------
    // flag registers
    // ----------------------------------------------------------
    // an op update wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_q <= sfn_pkg::FLAG_RST;
            z_q <= sfn_pkg::FLAG_RST;
            c_q <= sfn_pkg::FLAG_RST;
            v_q <= sfn_pkg::FLAG_RST;
        end else if (take && (req.op != sfn_pkg::OP_NOP)) begin
            n_q <= n_d;
            z_q <= z_d;
            c_q <= c_d;
            v_q <= v_d;
        end else if (wr_stat) begin
            n_q <= pwdata[sfn_pkg::N_BIT];
            z_q <= pwdata[sfn_pkg::Z_BIT];
            c_q <= pwdata[sfn_pkg::C_BIT];
            v_q <= pwdata[sfn_pkg::V_BIT];
        end
    end

    // ----------------------------------------------------------
    // result and condition outputs
    // ----------------------------------------------------------
    // result stands until the next accepted op that writes one; compare, carry and condition ops leave it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_q <= 32'h0000_0000;
            rv_q  <= 1'b0;
        end else begin
            res_q <= res_d;
            rv_q  <= take && (req.op != sfn_pkg::OP_NOP) &&
                     (req.op != sfn_pkg::OP_COND);
        end
    end

    // condition outcome stands until the next accepted test
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ct_q <= 1'b0;
        end else if (take && (req.op == sfn_pkg::OP_COND)) begin
            ct_q <= ct_d;
        end
    end

    // ----------------------------------------------------------
    // control register
    // ----------------------------------------------------------
    // enable gates every flag update from the decoder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= sfn_pkg::CTRL_EN_RST;
        end else if (wr_ctrl) begin
            en_q <= pwdata[sfn_pkg::CTRL_EN_BIT];
        end
    end

    // ----------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------
    // one wait state; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q <= 1'b0;
            rd_q  <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdy_q <= acc;
            err_q <= acc && !hit_ctrl && !hit_stat;
            rd_q  <= 32'h0000_0000;
            if (acc && !pwrite && hit_ctrl) begin
                rd_q[sfn_pkg::CTRL_EN_BIT] <= en_q;
            end
            if (acc && !pwrite && hit_stat) begin
                rd_q[sfn_pkg::N_BIT] <= n_q;
                rd_q[sfn_pkg::Z_BIT] <= z_q;
                rd_q[sfn_pkg::C_BIT] <= c_q;
                rd_q[sfn_pkg::V_BIT] <= v_q;
            end
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    assign pready       = rdy_q;
    assign prdata       = rd_q;
    assign pslverr      = err_q;
    assign neg_flag     = n_q;
    assign zero_flag    = z_q;
    assign carry_flag   = c_q;
    assign ovf_flag     = v_q;
    assign result       = res_q;
    assign result_valid = rv_q;
    assign cond_true    = ct_q;

endmodule

// *** dv/sfn_flags_sva.sv ***
// Purpose: port assertions for the status flag block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   pr_q keeps the request taken at the previous edge
`timescale 1ns/1ps
module sfn_flags_sva (
    input wire logic              pclk,         // cpu clock
    input wire logic              presetn,      // reset, low
    input wire logic              psel,         // apb select
    input wire logic              penable,      // apb access
    input wire logic              pwrite,       // apb direction
    input wire sfn_pkg::sfn_req_t req,          // decoder request
    input wire logic              neg_flag,     // negative flag
    input wire logic              carry_flag,   // carry flag
    input wire logic [31:0]       result,       // op result
    input wire logic              result_valid, // result strobe
    input wire logic              cond_true     // condition outcome
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    sfn_pkg::sfn_req_t pr_q; // request of the previous edge
    logic [32:0]       dw;   // exact signed difference
    logic [32:0]       sw;   // sum with carry out

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // remember the request so a result can be tied to its operands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pr_q <= '0;
        end else begin
            pr_q <= req;
        end
    end
    // sign-extended difference keeps the sign an overflow would lose
    assign dw = {pr_q.a[31], pr_q.a} - {pr_q.b[31], pr_q.b};
    assign sw = {1'b0, pr_q.a} + {1'b0, pr_q.b};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_sub_cond;
        req.valid && req.op == sfn_pkg::OP_SUB ##1
        result_valid && req.valid && req.op == sfn_pkg::OP_COND && req.cond == sfn_pkg::CC_LO;
    endsequence
    property p_sub_neg;
        result_valid && pr_q.wide && pr_q.op == sfn_pkg::OP_SUB |-> neg_flag == result[31];
    endproperty
    a_sub_neg: assert property (p_sub_neg) else $error("n not bit 31");
    property p_half_neg;
        result_valid && !pr_q.wide && pr_q.op inside {sfn_pkg::OP_ADD, sfn_pkg::OP_SUB}
        |-> neg_flag == result[15] && result[31:16] == 16'h0000;
    endproperty
    a_half_neg: assert property (p_half_neg) else $error("n not bit 15");
    property p_cmp_neg;
        result_valid && pr_q.wide && pr_q.op inside {sfn_pkg::OP_CMP, sfn_pkg::OP_MIN,
        sfn_pkg::OP_MAX} |-> neg_flag == dw[32] && carry_flag == (pr_q.a >= pr_q.b);
    endproperty
    a_cmp_neg: assert property (p_cmp_neg) else $error("cmp flags");
    property p_add_carry;
        result_valid && pr_q.wide && !pr_q.shift16 && pr_q.op == sfn_pkg::OP_ADD
        |-> carry_flag == sw[32] && result == sw[31:0];
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry");
    property p_add16_keep;
        result_valid && pr_q.shift16 && pr_q.op == sfn_pkg::OP_ADD && $past(carry_flag)
        |-> carry_flag;
    endproperty
    a_add16_keep: assert property (p_add16_keep) else $error("add16 cleared c");
    property p_sub16_keep;
        result_valid && pr_q.shift16 && pr_q.op == sfn_pkg::OP_SUB && !$past(carry_flag)
        |-> !carry_flag;
    endproperty
    a_sub16_keep: assert property (p_sub16_keep) else $error("sub16 set c");
    property p_cond_keep;
        pr_q.valid && pr_q.op == sfn_pkg::OP_COND && !($past(penable) && $past(pwrite))
        |-> $stable(carry_flag);
    endproperty
    a_cond_keep: assert property (p_cond_keep) else $error("cond moved c");
    property p_b2b;
        s_sub_cond |=> cond_true == !carry_flag;
    endproperty
    a_b2b: assert property (p_b2b) else $error("stale c");
endmodule

bind sfn_flags sfn_flags_sva sfn_flags_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .req(req), .neg_flag(neg_flag), .carry_flag(carry_flag),
    .result(result), .result_valid(result_valid), .cond_true(cond_true)
);

// *** dv/sfn_dec_model.sv ***
// Purpose: decoder model presenting requests to the flag block
// Assumes: put is entered just after a rising edge
// Notes:   released operand lines show inverted data, never stale
`timescale 1ns/1ps
module sfn_dec_model (
    input  wire logic         pclk, // cpu clock
    output sfn_pkg::sfn_req_t req   // request out
);
    // ----------------------------------------
    // request driving
    // ----------------------------------------
    initial req = '0;
    // hold a request over the edge that takes it
    task automatic put(input sfn_pkg::sfn_req_t r);
        req <= r;
        @(posedge pclk);
    endtask
    // drop valid, scramble operands, wait to mid-cycle
    task automatic rel();
        req.valid <= 1'b0;
        req.a     <= ~req.a;
        req.b     <= ~req.b;
        @(negedge pclk);
    endtask
endmodule

// *** dv/sfn_flags_bench.sv ***
// Purpose: self-checking bench for the status flag block
// Assumes: decoder model drives req, apb task drives registers
// Notes:   flags are compared half a cycle after the taking edge
`timescale 1ns/1ps
module sfn_flags_bench;
    logic              pclk;                    // cpu clock
    logic              presetn    = 1'b0;       // reset, low
    logic              psel       = 1'b0;       // apb select
    logic              penable    = 1'b0;       // apb access
    logic              pwrite     = 1'b0;       // apb direction
    logic [7:0]        paddr      = 8'h00;      // apb address
    logic [31:0]       pwdata     = 32'h0000_0000; // apb write data
    logic              pready, pslverr;         // apb answer
    logic [31:0]       prdata, result, rd;      // read data, result, last read
    sfn_pkg::sfn_req_t req;                     // decoder request
    logic              neg_flag, zero_flag, carry_flag, ovf_flag; // flags
    logic              result_valid, cond_true, err; // strobes, last error
    logic              held       = 1'b0;       // request kept for next op
    int                n_mismatch = 0;          // mismatches
    int                compares   = 0;          // comparisons

    sfn_flags sfn_flags_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .req(req), .neg_flag(neg_flag),
        .zero_flag(zero_flag), .carry_flag(carry_flag), .ovf_flag(ovf_flag),
        .result(result), .result_valid(result_valid), .cond_true(cond_true)
    );
    sfn_dec_model sfn_dec_model_i (.pclk(pclk), .req(req));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // flags as {negative, zero, carry}
    task automatic fl(input logic [2:0] e);
        chk({29'h0, neg_flag, zero_flag, carry_flag}, {29'h0, e});
    endtask
    // one request; h keeps valid up so the next op follows back to back
    task automatic op(input sfn_pkg::sfn_op_t o, input logic w, input logic [31:0] a,
                      input logic [31:0] b, input logic s = 1'b0, input logic [4:0] n = 5'h00,
                      input sfn_pkg::sfn_cc_t cc = sfn_pkg::CC_UNC, input logic h = 1'b0);
        if (!held) @(posedge pclk);
        sfn_dec_model_i.put('{1'b1, o, w, s, n, cc, a, b});
        held = h;
        if (!h) sfn_dec_model_i.rel();
    endtask
    // shift and compare carry and result
    task automatic sh(input sfn_pkg::sfn_op_t o, input logic w, input logic [31:0] a,
                      input logic [4:0] n, input logic c, input logic [31:0] r);
        op(o, w, a, 32'h0000_0000, 1'b0, n);
        chk({30'h0, result_valid, carry_flag}, {30'h0, 1'b1, c});
        chk(result, r);
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard, far past the test length
    initial begin
        #100_000;
        n_mismatch++;
        tally_and_finish();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        fl(3'h0);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
        op(sfn_pkg::OP_SUB, 1'b1, 32'h0000_0005, 32'h0000_0007, 1'b0, 5'h00,
           sfn_pkg::CC_UNC, 1'b1);
        op(sfn_pkg::OP_COND, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0, 5'h00, sfn_pkg::CC_LO);
        fl(3'h4);
        chk({31'h0, cond_true}, 32'h0000_0001);
        op(sfn_pkg::OP_SUB, 1'b1, 32'h8000_0000, 32'h0000_0001);
        fl(3'h1);
        chk(result, 32'h7FFF_FFFF);
        $display("test subtract done");
        for (sfn_pkg::sfn_op_t o = sfn_pkg::OP_CMP; o <= sfn_pkg::OP_MAX; o = o.next()) begin
            op(o, 1'b1, 32'h8000_0000, 32'h0000_0001);
            fl(3'h5);
            op(o, 1'b1, 32'h7FFF_FFFF, 32'hFFFF_FFFF);
            fl(3'h0);
        end
        op(sfn_pkg::OP_CMP, 1'b0, 32'h0000_8000, 32'h0000_0001);
        fl(3'h5);
        $display("test compare done");
        op(sfn_pkg::OP_ADD, 1'b1, 32'hFFFF_FFFF, 32'h0000_0001);
        fl(3'h3);
        op(sfn_pkg::OP_ADD, 1'b1, 32'h0000_0001, 32'h0000_0001);
        fl(3'h0);
        op(sfn_pkg::OP_ADD, 1'b0, 32'h0000_7FFF, 32'h0000_0001);
        fl(3'h4);
        chk(result, 32'h0000_8000);
        op(sfn_pkg::OP_SETC, 1'b1, 32'h0000_0000, 32'h0000_0000);
        fl(3'h5);
        op(sfn_pkg::OP_ADDC, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000);
        fl(3'h3);
        op(sfn_pkg::OP_CLRC, 1'b1, 32'h0000_0000, 32'h0000_0000);
        fl(3'h2);
        op(sfn_pkg::OP_SUB, 1'b1, 32'hFFFF_FFFF, 32'h0000_0001, 1'b1);
        fl(3'h4);
        op(sfn_pkg::OP_SETC, 1'b1, 32'h0000_0000, 32'h0000_0000);
        op(sfn_pkg::OP_ADD, 1'b1, 32'h0000_0000, 32'h0000_0001, 1'b1);
        fl(3'h1);
        $display("test add done");
        sh(sfn_pkg::OP_SHL, 1'b1, 32'h4000_0000, 5'h02, 1'b1, 32'h0000_0000);
        sh(sfn_pkg::OP_SHL, 1'b1, 32'h4000_0000, 5'h00, 1'b0, 32'h4000_0000);
        sh(sfn_pkg::OP_SHL, 1'b0, 32'h0000_4000, 5'h02, 1'b1, 32'h0000_0000);
        sh(sfn_pkg::OP_SHR, 1'b0, 32'h0000_0004, 5'h03, 1'b1, 32'h0000_0000);
        sh(sfn_pkg::OP_SHR, 1'b0, 32'h0000_0004, 5'h00, 1'b0, 32'h0000_0004);
        $display("test shift done");
        op(sfn_pkg::OP_CHECK, 1'b1, 32'h0000_0000, 32'h0000_0000);
        fl(3'h2);
        op(sfn_pkg::OP_CHECK, 1'b1, 32'h8000_0000, 32'h0000_0000);
        fl(3'h4);
        chk({31'h0, ovf_flag}, 32'h0000_0001);
        op(sfn_pkg::OP_COND, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0, 5'h00, sfn_pkg::CC_OV);
        chk({31'h0, ovf_flag}, 32'h0000_0000);
        chk({31'h0, cond_true}, 32'h0000_0001);
        $display("test check done");
        apb(1'b1, 8'h00, 32'h0000_0000);
        op(sfn_pkg::OP_ADD, 1'b1, 32'hFFFF_FFFF, 32'h0000_0001);
        chk({28'h0, result_valid, neg_flag, zero_flag, carry_flag}, 32'h0000_0004);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h04, 32'h0000_0018);
        fl(3'h3);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0018);
        $display("test registers done");
        tally_and_finish();
    end
endmodule
